/* hw/diag_message_logger.sv */
// Diagnostic message logger: alarm buffer and history, fault buffer, counters.
//
// Operation
// - Alarm history holds up to fifty-six entries.
// - Only removed alarms may enter history.
// - Full buffer plus new alarm flushes removed.
// - Youngest moved alarm lands at history index 8.
// - Active alarms stay, buffer compacted without gaps.
// - History full: oldest entry discarded per insert.
// - Count alarms since last clear, expose counter.
// - Writing zero to counter flushes removed alarms.
// - Current alarm code is most recent arrival.
// - Record alarm removal time, days and ms.
// - Twenty-entry table: fault, alarm or suppress.
// - Any fault present sets status bit 3.
// - Fault clears only after cause gone and acknowledge.
// - Store fault code, both values, arrival time.
// - Fault arrival time as days plus ms.
// - Fault removal time not kept; acknowledge drops the entry.
// - Further faults take next slot, earlier kept.
// - Count fault cases; case groups several faults.
// - Eight fault slots; overflow overwrites next-to-last.
// - Eight alarm slots; overflow overwrites next-to-last.
// - Runtime ms wraps at 86,400,000, days increment.
// - Any active alarm sets status bit 7.
`timescale 1ns/1ns
module diag_message_logger #(
  parameter int unsigned TICK_CYCLES = diag_pkg::MS_TICK_CYCLES
) (
  input  wire logic                   mclk_i,                 // System clock, 10 MHz.
  input  wire logic                   rstn_i,                 // Asynchronous reset, active low.
  input  wire logic                   msg_valid_i,            // New message arrives this cycle.
  input  diag_pkg::msg_t              msg_i,                  // Code, values and native kind.
  input  wire logic                   alarm_gone_i,           // Cause of an alarm removed.
  input  wire logic [15:0]            alarm_gone_code_i,      // Code of the removed alarm.
  input  wire logic                   fault_gone_i,           // Cause of a fault removed.
  input  wire logic [15:0]            fault_gone_code_i,      // Code of the removed fault.
  input  wire logic                   fault_ack_i,            // Fault acknowledgement.
  input  wire logic                   alarm_counter_wr_i,     // Write the alarm counter.
  input  wire logic [15:0]            alarm_counter_i,        // Value for the alarm counter.
  input  wire logic                   fault_case_counter_wr_i, // Write the fault-case counter.
  input  wire logic [15:0]            fault_case_counter_i,   // Value for the fault-case counter.
  input  wire logic                   reclass_wr_i,           // Write a reclassification entry.
  input  diag_pkg::reclass_wr_t       reclass_i,              // Reclassification entry.
  input  wire logic [5:0]             alarm_rd_idx_i,         // Alarm index 0..63 to read.
  input  wire logic [2:0]             fault_rd_idx_i,         // Fault slot 0..7 to read.
  output diag_pkg::entry_t            alarm_entry_o,          // Selected alarm entry.
  output diag_pkg::entry_t            fault_entry_o,          // Selected fault entry.
  output logic [15:0]                 current_alarm_code_o,   // Most recent alarm code.
  output logic [15:0]                 alarm_counter_o,        // Alarms since last clear.
  output logic [15:0]                 fault_case_counter_o,   // Fault cases counted.
  output logic [15:0]                 first_status_word_o,    // Status word, bits 3 and 7.
  output diag_pkg::stamp_t            runtime_o               // System runtime.
);
  import diag_pkg::*;

  typedef struct packed {
    alarm_store_t              al;
    entry_t [FAULT_SLOTS-1:0]  flt;
    logic [CODE_W-1:0]         cur_alarm;
    logic [CNT_W-1:0]          alarm_cnt;
    logic [CNT_W-1:0]          fault_cases;
    logic [STW_W-1:0]          stw;
    entry_t                    alarm_rd;
    entry_t                    fault_rd;
  } log_state_t;

  logic [1:0]  rst_sync_ff;
  logic        rst_n;
  log_state_t  state_ff;
  log_state_t  nxt_state;
  stamp_t      now;
  logic [1:0]  table_type;

  // The reset enters asynchronously but is released only on a clock edge.
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_ff[1];

  runtime_counter #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_runtime (
    .mclk_i    (mclk_i),
    .rst_n_i   (rst_n),
    .runtime_o (now)
  );

  reclass_table u_reclass (
    .mclk_i    (mclk_i),
    .rst_n_i   (rst_n),
    .wr_i      (reclass_wr_i),
    .wr_data_i (reclass_i),
    .code_i    (msg_i.code),
    .mtype_o   (table_type)
  );

  function automatic logic [3:0] count_valid(input entry_t [7:0] e);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 0; i < 8; i++) begin
      c = c + {3'h0, e[i].valid};
    end
    return c;
  endfunction

  function automatic logic any_removed(input entry_t [ALARM_SLOTS-1:0] e);
    logic r;
    r = 1'b0;
    for (int i = 0; i < ALARM_SLOTS; i++) begin
      r = r | (e[i].valid & e[i].removed);
    end
    return r;
  endfunction

  // Removed alarms are pushed oldest first onto the front of the history, so the
  // youngest ends at the front; active alarms are packed down in arrival order.
  function automatic alarm_store_t flush_removed(input alarm_store_t st);
    alarm_store_t r;
    logic [2:0]   k;
    r       = st;
    r.buf_e = '0;
    k       = 3'h0;
    for (int i = 0; i < ALARM_SLOTS; i++) begin
      if (st.buf_e[i].valid && st.buf_e[i].removed) begin
        r.hist = {r.hist[HIST_SLOTS-2:0], st.buf_e[i]};
      end else if (st.buf_e[i].valid) begin
        r.buf_e[k] = st.buf_e[i];
        k          = k + 3'h1;
      end
    end
    return r;
  endfunction

  function automatic entry_t make_entry(input msg_t m, input stamp_t t);
    entry_t e;
    e           = '0;
    e.valid     = 1'b1;
    e.code      = m.code;
    e.val_fixed = m.val_fixed;
    e.val_float = m.val_float;
    e.arrived   = t;
    return e;
  endfunction

  always_comb begin
    logic [1:0]  kind;
    logic        found;
    logic [3:0]  n_used;
    logic [2:0]  k;
    entry_t [FAULT_SLOTS-1:0] packed_flt;
    logic        alarm_active;
    logic        fault_present;
    kind          = MSG_NONE;
    found         = 1'b0;
    n_used        = 4'h0;
    k             = 3'h0;
    packed_flt    = '0;
    alarm_active  = 1'b0;
    fault_present = 1'b0;
    nxt_state     = state_ff;

    // Cause removal of an alarm stamps the first matching active entry.
    if (alarm_gone_i) begin
      for (int i = 0; i < ALARM_SLOTS; i++) begin
        if (!found && state_ff.al.buf_e[i].valid && !state_ff.al.buf_e[i].removed
            && state_ff.al.buf_e[i].code == alarm_gone_code_i) begin
          nxt_state.al.buf_e[i].removed = 1'b1;
          nxt_state.al.buf_e[i].gone    = now;
          found                         = 1'b1;
        end
      end
    end

    // A fault whose cause has gone stays in the buffer until acknowledged.
    found = 1'b0;
    if (fault_gone_i) begin
      for (int i = 0; i < FAULT_SLOTS; i++) begin
        if (!found && state_ff.flt[i].valid && !state_ff.flt[i].removed
            && state_ff.flt[i].code == fault_gone_code_i) begin
          nxt_state.flt[i].removed = 1'b1;
          found                    = 1'b1;
        end
      end
    end

    // Acknowledge releases only faults whose cause has gone; survivors are packed down.
    if (fault_ack_i) begin
      for (int i = 0; i < FAULT_SLOTS; i++) begin
        if (nxt_state.flt[i].valid && nxt_state.flt[i].removed) begin
          nxt_state.flt[i].gone = now;
        end else if (nxt_state.flt[i].valid) begin
          packed_flt[k] = nxt_state.flt[i];
          k             = k + 3'h1;
        end
      end
      nxt_state.flt = packed_flt;
    end

    if (alarm_counter_wr_i) begin
      nxt_state.alarm_cnt = alarm_counter_i;
      if (alarm_counter_i == COUNTER_RST) begin
        nxt_state.al = flush_removed(nxt_state.al);
      end
    end

    if (fault_case_counter_wr_i) begin
      nxt_state.fault_cases = fault_case_counter_i;
    end

    // Table type overrides the native kind; a suppressed message goes nowhere.
    if (msg_valid_i) begin
      kind = (table_type != MSG_KEEP) ? table_type
           : (msg_i.is_fault ? MSG_FAULT : MSG_ALARM);
    end

    if (msg_valid_i && kind == MSG_ALARM) begin
      nxt_state.cur_alarm = msg_i.code;
      nxt_state.alarm_cnt = nxt_state.alarm_cnt + 16'h1;
      if (count_valid(nxt_state.al.buf_e) == 4'(ALARM_SLOTS)
          && any_removed(nxt_state.al.buf_e)) begin
        nxt_state.al = flush_removed(nxt_state.al);
      end
      n_used = count_valid(nxt_state.al.buf_e);
      if (n_used == 4'(ALARM_SLOTS)) begin
        nxt_state.al.buf_e[OVERWRITE_SLOT] = make_entry(msg_i, now);
      end else begin
        nxt_state.al.buf_e[n_used[2:0]] = make_entry(msg_i, now);
      end
    end

    if (msg_valid_i && kind == MSG_FAULT) begin
      n_used = count_valid(nxt_state.flt);
      if (n_used == 4'h0) begin
        nxt_state.fault_cases = nxt_state.fault_cases + 16'h1;
      end
      if (n_used == 4'(FAULT_SLOTS)) begin
        nxt_state.flt[OVERWRITE_SLOT] = make_entry(msg_i, now);
      end else begin
        nxt_state.flt[n_used[2:0]] = make_entry(msg_i, now);
      end
    end

    for (int i = 0; i < ALARM_SLOTS; i++) begin
      alarm_active = alarm_active
                   | (nxt_state.al.buf_e[i].valid & ~nxt_state.al.buf_e[i].removed);
    end
    for (int i = 0; i < FAULT_SLOTS; i++) begin
      fault_present = fault_present | nxt_state.flt[i].valid;
    end
    nxt_state.stw                = '0;
    nxt_state.stw[STW_FAULT_BIT] = fault_present;
    nxt_state.stw[STW_ALARM_BIT] = alarm_active;

    // Index 0..7 reads the alarm buffer, 8..63 the history.
    if (int'(alarm_rd_idx_i) < HIST_BASE) begin
      nxt_state.alarm_rd = nxt_state.al.buf_e[alarm_rd_idx_i[2:0]];
    end else begin
      nxt_state.alarm_rd = nxt_state.al.hist[6'(alarm_rd_idx_i - 6'(HIST_BASE))];
    end
    nxt_state.fault_rd = nxt_state.flt[fault_rd_idx_i];
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_ff             <= '0;
      state_ff.alarm_cnt   <= COUNTER_RST;
      state_ff.fault_cases <= COUNTER_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign alarm_entry_o        = state_ff.alarm_rd;
  assign fault_entry_o        = state_ff.fault_rd;
  assign current_alarm_code_o = state_ff.cur_alarm;
  assign alarm_counter_o      = state_ff.alarm_cnt;
  assign fault_case_counter_o = state_ff.fault_cases;
  assign first_status_word_o  = state_ff.stw;
  assign runtime_o            = now;

endmodule // diag_message_logger

/* hw/diag_pkg.sv */
// Shared constants, message types and entry layouts of the diagnostic message logger.
package diag_pkg;

  localparam int CODE_W = 16;
  localparam int VAL_W  = 32;
  localparam int DAY_W  = 16;
  localparam int MS_W   = 32;
  localparam int CNT_W  = 16;
  localparam int STW_W  = 16;

  localparam int ALARM_SLOTS     = 8;
  localparam int FAULT_SLOTS     = 8;
  localparam int HIST_BASE       = 8;
  localparam int HIST_TOP        = 63;
  localparam int HIST_SLOTS      = HIST_TOP - HIST_BASE + 1;
  localparam int OVERWRITE_SLOT  = 6;
  localparam int RECLASS_ENTRIES = 20;
  localparam int RD_IDX_W        = 6;
  localparam int RECLASS_IDX_W   = 5;

  localparam int STW_FAULT_BIT = 3;
  localparam int STW_ALARM_BIT = 7;

  localparam logic [MS_W-1:0]  MS_PER_DAY  = 32'h0526_5C00;
  localparam logic [CNT_W-1:0] COUNTER_RST = 16'h0000;

  localparam int CLK_PERIOD_NS  = 100;
  localparam int MS_TICK_NS     = 1000000;
  localparam int MS_TICK_CYCLES = MS_TICK_NS / CLK_PERIOD_NS;
  localparam int DIV_W          = 16;

  localparam logic [1:0] MSG_KEEP  = 2'h0;
  localparam logic [1:0] MSG_FAULT = 2'h1;
  localparam logic [1:0] MSG_ALARM = 2'h2;
  localparam logic [1:0] MSG_NONE  = 2'h3;

  typedef struct packed {
    logic [DAY_W-1:0] days;
    logic [MS_W-1:0]  ms;
  } stamp_t;

  typedef struct packed {
    logic              valid;
    logic              removed;
    logic [CODE_W-1:0] code;
    logic [VAL_W-1:0]  val_fixed;
    logic [VAL_W-1:0]  val_float;
    stamp_t            arrived;
    stamp_t            gone;
  } entry_t;

  typedef struct packed {
    logic [CODE_W-1:0] code;
    logic [VAL_W-1:0]  val_fixed;
    logic [VAL_W-1:0]  val_float;
    logic              is_fault;
  } msg_t;

  typedef struct packed {
    logic [RECLASS_IDX_W-1:0] idx;
    logic [CODE_W-1:0]        number;
    logic [1:0]               mtype;
  } reclass_wr_t;

  typedef struct packed {
    entry_t [HIST_SLOTS-1:0]  hist;
    entry_t [ALARM_SLOTS-1:0] buf_e;
  } alarm_store_t;

endpackage

/* hw/reclass_table.sv */
// Message reclassification table: message number to new message type.
`timescale 1ns/1ns
module reclass_table (
  input  wire logic                  mclk_i,   // System clock.
  input  wire logic                  rst_n_i,  // Synchronised reset, active low.
  input  wire logic                  wr_i,     // Write one table entry.
  input  diag_pkg::reclass_wr_t      wr_data_i, // Entry index, message number and type.
  input  wire logic [15:0]           code_i,   // Message code to look up.
  output logic [1:0]                 mtype_o   // Type for code, zero when not listed.
);
  import diag_pkg::*;

  typedef struct packed {
    logic [CODE_W-1:0] number;
    logic [1:0]        mtype;
  } rc_entry_t;

  typedef struct packed {
    rc_entry_t [RECLASS_ENTRIES-1:0] tab;
  } rc_state_t;

  rc_state_t state_ff;
  rc_state_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    if (wr_i && (int'(wr_data_i.idx) < RECLASS_ENTRIES)) begin
      nxt_state.tab[wr_data_i.idx].number = wr_data_i.number;
      nxt_state.tab[wr_data_i.idx].mtype  = wr_data_i.mtype;
    end
  end

  // The lowest matching entry wins; type zero marks an unused entry.
  always_comb begin
    mtype_o = MSG_KEEP;
    for (int i = RECLASS_ENTRIES - 1; i >= 0; i--) begin
      if (state_ff.tab[i].mtype != MSG_KEEP && state_ff.tab[i].number == code_i) begin
        mtype_o = state_ff.tab[i].mtype;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

endmodule // reclass_table

/* hw/runtime_counter.sv */
// System runtime counter: milliseconds within the day plus whole days.
`timescale 1ns/1ns
module runtime_counter #(
  parameter int unsigned TICK_CYCLES = diag_pkg::MS_TICK_CYCLES
) (
  input  wire logic             mclk_i,    // System clock.
  input  wire logic             rst_n_i,   // Synchronised reset, active low.
  output diag_pkg::stamp_t      runtime_o  // Current runtime stamp.
);
  import diag_pkg::*;

  typedef struct packed {
    logic [DIV_W-1:0] div;
    stamp_t           now;
  } rt_state_t;

  rt_state_t state_ff;
  rt_state_t nxt_state;

  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);

  always_comb begin
    nxt_state = state_ff;
    if (state_ff.div == DIV_LAST) begin
      nxt_state.div = '0;
      if (state_ff.now.ms == MS_PER_DAY - 32'h1) begin
        nxt_state.now.ms   = '0;
        nxt_state.now.days = state_ff.now.days + 16'h1;
      end else begin
        nxt_state.now.ms = state_ff.now.ms + 32'h1;
      end
    end else begin
      nxt_state.div = state_ff.div + 16'h1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign runtime_o = state_ff.now;

endmodule // runtime_counter

/* verification/diag_message_logger_asserts.sv */
// Port-level checks of the diagnostic message logger, bound to its top module.
`timescale 1ns/1ns
module diag_message_logger_asserts
  import diag_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = MS_TICK_CYCLES
) (
  input wire logic        mclk_i,                  // Clock.
  input wire logic        rstn_i,                  // Reset, active low.
  input wire logic        msg_valid_i,             // Message strobe.
  input diag_pkg::msg_t   msg_i,                   // Message.
  input wire logic        fault_ack_i,             // Acknowledge.
  input wire logic        alarm_counter_wr_i,      // Counter write.
  input wire logic [15:0] alarm_counter_i,         // Counter value.
  input wire logic        fault_case_counter_wr_i, // Case counter write.
  input wire logic        reclass_wr_i,            // Table write.
  input diag_pkg::entry_t alarm_entry_o,           // Alarm entry.
  input wire logic [15:0] current_alarm_code_o,    // Current alarm.
  input wire logic [15:0] alarm_counter_o,         // Alarm count.
  input wire logic [15:0] fault_case_counter_o,    // Case count.
  input wire logic [15:0] first_status_word_o,     // Status word.
  input diag_pkg::stamp_t runtime_o                // Runtime.
);
  typedef struct packed {
    logic        reclassed;
    logic [15:0] code;
    logic [15:0] wr_val;
  } watch_t;
  watch_t watch_ff;
  watch_t nxt_watch;
  logic   plain_alarm;
  logic   plain_fault;

  // Native kinds are only trusted while the table has never been written.
  assign plain_alarm = msg_valid_i && !msg_i.is_fault && !watch_ff.reclassed && !reclass_wr_i;
  assign plain_fault = msg_valid_i && msg_i.is_fault && !watch_ff.reclassed && !reclass_wr_i;

  always_comb begin
    nxt_watch = watch_ff;
    if (reclass_wr_i) nxt_watch.reclassed = 1'b1;
    if (plain_alarm) nxt_watch.code = msg_i.code;
    if (alarm_counter_wr_i) nxt_watch.wr_val = alarm_counter_i;
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) watch_ff <= '0;
    else watch_ff <= nxt_watch;
  end

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);

  AST_ALARM_STATUS: assert property (
    plain_alarm |-> ##[1:2] first_status_word_o[STW_ALARM_BIT]) else $error("alarm bit not set");
  AST_FAULT_STATUS: assert property (
    plain_fault |-> ##[1:2] first_status_word_o[STW_FAULT_BIT]) else $error("fault bit not set");
  AST_ALARM_CODE: assert property (
    plain_alarm |-> ##[1:2] current_alarm_code_o == watch_ff.code) else $error("wrong alarm code");
  AST_FAULT_HELD: assert property (
    $fell(first_status_word_o[STW_FAULT_BIT]) |-> $past(fault_ack_i) || $past(fault_ack_i, 2))
    else $error("fault cleared without ack");
  AST_CODE_CAUSE: assert property (
    $changed(current_alarm_code_o) |-> $past(msg_valid_i) || $past(msg_valid_i, 2))
    else $error("alarm code changed alone");
  AST_COUNT_CAUSE: assert property (
    $changed(alarm_counter_o) |-> $past(msg_valid_i) || $past(msg_valid_i, 2)
      || $past(alarm_counter_wr_i) || $past(alarm_counter_wr_i, 2))
    else $error("alarm counter changed alone");
  AST_COUNT_WRITE: assert property (
    alarm_counter_wr_i && !msg_valid_i |-> ##[1:2] alarm_counter_o == watch_ff.wr_val)
    else $error("counter write lost");
  AST_CASE_CAUSE: assert property (
    $changed(fault_case_counter_o) |-> $past(msg_valid_i) || $past(msg_valid_i, 2)
      || $past(fault_case_counter_wr_i) || $past(fault_case_counter_wr_i, 2))
    else $error("case counter changed alone");
  AST_RUNTIME_STEP: assert property (
    $changed(runtime_o.ms) && runtime_o.ms != '0 |-> runtime_o.ms == $past(runtime_o.ms) + 32'h1)
    else $error("runtime ms skipped");
  AST_DAY_WRAP: assert property (
    $changed(runtime_o.days) |-> runtime_o.ms == '0 && $past(runtime_o.ms) == MS_PER_DAY - 32'h1)
    else $error("day count moved off wrap");
  AST_EMPTY_SLOT: assert property (
    !alarm_entry_o.valid |-> alarm_entry_o.code == '0) else $error("empty slot shows a code");
endmodule // diag_message_logger_asserts

bind diag_message_logger diag_message_logger_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .mclk_i(mclk_i), .rstn_i(rstn_i), .msg_valid_i(msg_valid_i), .msg_i(msg_i),
  .fault_ack_i(fault_ack_i), .alarm_counter_wr_i(alarm_counter_wr_i),
  .alarm_counter_i(alarm_counter_i), .fault_case_counter_wr_i(fault_case_counter_wr_i),
  .reclass_wr_i(reclass_wr_i), .alarm_entry_o(alarm_entry_o),
  .current_alarm_code_o(current_alarm_code_o), .alarm_counter_o(alarm_counter_o),
  .fault_case_counter_o(fault_case_counter_o), .first_status_word_o(first_status_word_o),
  .runtime_o(runtime_o));

/* verification/tb.sv */
// Self-checking bench of the diagnostic message logger.
`timescale 1ns/1ns
module tb;
  import diag_pkg::*;
  logic        mclk_i = 1'b0, rstn_i = 1'b0, msg_valid_i = 1'b0, alarm_gone_i = 1'b0;
  logic        fault_gone_i = 1'b0, fault_ack_i = 1'b0, alarm_counter_wr_i = 1'b0;
  logic        fault_case_counter_wr_i = 1'b0, reclass_wr_i = 1'b0;
  logic [15:0] alarm_gone_code_i = '0, fault_gone_code_i = '0, alarm_counter_i = '0;
  logic [15:0] fault_case_counter_i = '0, current_alarm_code_o, alarm_counter_o, cnt;
  logic [15:0] fault_case_counter_o, first_status_word_o;
  logic [5:0]  alarm_rd_idx_i = '0;
  logic [2:0]  fault_rd_idx_i = '0;
  msg_t        msg_i = '0;
  reclass_wr_t reclass_i = '0;
  entry_t      alarm_entry_o, fault_entry_o, e;
  stamp_t      runtime_o;
  int          failures = 0, tests_run = 0;
  int          bk[6] = '{0, 2, 5, 6, 7, 8};
  int          cl[7] = '{5, 6, 7, 8, 11, 10, 12};

  always #50 mclk_i = ~mclk_i;

  diag_message_logger #(.TICK_CYCLES(4)) dut (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .msg_valid_i(msg_valid_i), .msg_i(msg_i),
    .alarm_gone_i(alarm_gone_i), .alarm_gone_code_i(alarm_gone_code_i),
    .fault_gone_i(fault_gone_i), .fault_gone_code_i(fault_gone_code_i),
    .fault_ack_i(fault_ack_i), .alarm_counter_wr_i(alarm_counter_wr_i),
    .alarm_counter_i(alarm_counter_i), .fault_case_counter_wr_i(fault_case_counter_wr_i),
    .fault_case_counter_i(fault_case_counter_i), .reclass_wr_i(reclass_wr_i),
    .reclass_i(reclass_i), .alarm_rd_idx_i(alarm_rd_idx_i), .fault_rd_idx_i(fault_rd_idx_i),
    .alarm_entry_o(alarm_entry_o), .fault_entry_o(fault_entry_o),
    .current_alarm_code_o(current_alarm_code_o), .alarm_counter_o(alarm_counter_o),
    .fault_case_counter_o(fault_case_counter_o), .first_status_word_o(first_status_word_o),
    .runtime_o(runtime_o));

  function automatic logic [15:0] cd(input logic [15:0] b, input int k);
    return b + 16'(k);
  endfunction
  function automatic logic [15:0] sw(input logic a, input logic f);
    return (16'(a) << STW_ALARM_BIT) | (16'(f) << STW_FAULT_BIT);
  endfunction
  task automatic step(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  // Strobes are single-cycle; two idle cycles let the registered outputs settle.
  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
    step(2);
  endtask
  task automatic send(input logic [15:0] c, input logic f);
    msg_i = {c, 32'($urandom()), 32'($urandom()), f};
    pulse(msg_valid_i);
  endtask
  task automatic gone_a(input logic [15:0] c);
    alarm_gone_code_i = c;
    pulse(alarm_gone_i);
  endtask
  task automatic gone_f(input logic [15:0] c);
    fault_gone_code_i = c;
    pulse(fault_gone_i);
  endtask
  task automatic cw(input logic [15:0] v);
    alarm_counter_i = v;
    pulse(alarm_counter_wr_i);
  endtask
  task automatic rc(input logic [4:0] i, input logic [15:0] n, input logic [1:0] t);
    reclass_i = {i, n, t};
    pulse(reclass_wr_i);
  endtask
  task automatic ra(input logic [5:0] i);
    alarm_rd_idx_i = i;
    step(2);
    e = alarm_entry_o;
  endtask
  task automatic rf(input logic [2:0] i);
    fault_rd_idx_i = i;
    step(2);
    e = fault_entry_o;
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge mclk_i);
    failures++;
    give_verdict();
  end

  initial begin
    void'($urandom(99971));
    repeat (6) @(posedge mclk_i);
    @(negedge mclk_i);
    rstn_i = 1'b1;
    step(3);
    ra(6'd0);
    chk("empty code", e.code, 16'h0000);
    chk("status", first_status_word_o, 16'h0000);
    cnt = runtime_o.ms[15:0];
    step(40);
    chk("runtime", runtime_o.ms[15:0], cnt + 16'h000A);
    chk("days", runtime_o.days, 16'h0000);
    for (int i = 0; i < 60; i++) begin
      send(cd(16'h2000, i), 1'b0);
      gone_a(cd(16'h2000, i));
      cw(16'h0000);
    end
    ra(6'd8);
    chk("hist8", e.code, cd(16'h2000, 59));
    ra(6'd63);
    chk("hist63", e.code, cd(16'h2000, 4));
    for (int k = 0; k < 8; k++) send(cd(16'h3000, k), 1'b0);
    gone_a(cd(16'h3000, 1));
    gone_a(cd(16'h3000, 3));
    gone_a(cd(16'h3000, 4));
    ra(6'd4);
    chk("removed", e.removed, 1'b1);
    chk("gone ms", e.gone.ms != '0, 1'b1);
    chk("still active", first_status_word_o, sw(1'b1, 1'b0));
    send(cd(16'h3000, 8), 1'b0);
    ra(6'd8);
    chk("young", e.code, cd(16'h3000, 4));
    ra(6'd9);
    chk("next", e.code, cd(16'h3000, 3));
    ra(6'd10);
    chk("oldest", e.code, cd(16'h3000, 1));
    ra(6'd11);
    chk("shifted", e.code, cd(16'h2000, 59));
    for (int k = 0; k < 6; k++) begin
      ra(6'(k));
      chk("packed", e.code, cd(16'h3000, bk[k]));
    end
    ra(6'd6);
    chk("gap", e.valid, 1'b0);
    send(cd(16'h3000, 9), 1'b0);
    send(cd(16'h3000, 10), 1'b0);
    send(cd(16'h3000, 11), 1'b0);
    ra(6'd6);
    chk("overwrite", e.code, cd(16'h3000, 11));
    ra(6'd7);
    chk("last kept", e.code, cd(16'h3000, 10));
    chk("count", alarm_counter_o, 16'd12);
    gone_a(cd(16'h3000, 0));
    gone_a(cd(16'h3000, 2));
    cw(16'h0000);
    ra(6'd8);
    chk("flush young", e.code, cd(16'h3000, 2));
    ra(6'd9);
    chk("flush old", e.code, cd(16'h3000, 0));
    ra(6'd0);
    chk("compact", e.code, cd(16'h3000, 5));
    cnt = 16'($urandom());
    cw(cnt | 16'h0001);
    send(cd(16'h3000, 12), 1'b0);
    chk("count wr", alarm_counter_o, (cnt | 16'h0001) + 16'h1);
    chk("current", current_alarm_code_o, cd(16'h3000, 12));
    ra(6'd6);
    chk("alarm value", e.val_fixed, msg_i.val_fixed);
    foreach (cl[k]) gone_a(cd(16'h3000, cl[k]));
    chk("alarm off", first_status_word_o, 16'h0000);
    send(16'h4000, 1'b1);
    rf(3'd0);
    chk("fault code", e.code, 16'h4000);
    chk("fault float", e.val_float, msg_i.val_float);
    chk("fault day ms", e.arrived.ms != '0, 1'b1);
    chk("fault bit", first_status_word_o, sw(1'b0, 1'b1));
    chk("case", fault_case_counter_o, 16'd1);
    send(16'h4001, 1'b1);
    rf(3'd1);
    chk("next slot", e.code, 16'h4001);
    rf(3'd0);
    chk("first kept", e.code, 16'h4000);
    chk("one case", fault_case_counter_o, 16'd1);
    gone_f(16'h4000);
    chk("held", first_status_word_o, sw(1'b0, 1'b1));
    pulse(fault_ack_i);
    rf(3'd0);
    chk("acked out", e.code, 16'h4001);
    chk("no stamp", e.gone, '0);
    gone_f(16'h4001);
    pulse(fault_ack_i);
    chk("fault off", first_status_word_o, 16'h0000);
    for (int k = 0; k < 9; k++) send(cd(16'h4100, k), 1'b1);
    rf(3'd6);
    chk("f overwrite", e.code, cd(16'h4100, 8));
    rf(3'd7);
    chk("f last", e.code, cd(16'h4100, 7));
    chk("case2", fault_case_counter_o, 16'd2);
    for (int k = 0; k < 9; k++) gone_f(cd(16'h4100, k));
    pulse(fault_ack_i);
    rf(3'd0);
    chk("f empty", e.code, 16'h0000);
    fault_case_counter_i = 16'($urandom());
    pulse(fault_case_counter_wr_i);
    chk("case wr", fault_case_counter_o, fault_case_counter_i);
    cw(16'h0000);
    rc(5'd0, 16'h5000, MSG_NONE);
    rc(5'd1, 16'h5001, MSG_FAULT);
    rc(5'd2, 16'h5002, MSG_ALARM);
    rc(5'd20, 16'h5003, MSG_NONE);
    send(16'h5000, 1'b0);
    chk("suppress", alarm_counter_o, 16'd0);
    chk("silent", first_status_word_o, 16'h0000);
    send(16'h5001, 1'b0);
    chk("to fault", first_status_word_o, sw(1'b0, 1'b1));
    send(16'h5002, 1'b1);
    chk("to alarm", current_alarm_code_o, 16'h5002);
    send(16'h5003, 1'b0);
    chk("idx20 ignored", alarm_counter_o, 16'd2);
    give_verdict();
  end
endmodule // tb
